/* File: verilog/power_event_inputs.sv */
// Power-management event inputs: battery low, clock stop, external and lid
// management interrupts, PCI request monitor, with an Avalon-MM register slave.
// Assumes the bus master holds each request until waitrequest is seen low.
`timescale 1ns/100ps
module power_event_inputs #(
  parameter int DebounceCycles = pm_event_pkg::DebounceCycles
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic battery_low_n,
  input wire logic resume_request,
  output logic resume_start,
  output logic cpu_clock_stop_n,
  input wire logic external_mgmt_irq_n_in,
  output logic external_mgmt_irq_n_out,
  output logic external_mgmt_irq_n_oe,
  output logic system_mgmt_irq_n,
  input wire logic gp_input_lid_pin,
  input wire logic [3:0] pci_master_request_monitor_n,
  output logic pci_activity,
  output logic irq
);
  typedef struct packed {
    logic [2:0] batSync;
    logic [2:0] extSync;
    logic [2:0] lidSync;
    logic [3:0][2:0] reqSync;
    logic batLevel;
    logic extLevel;
    logic lidLevel;
    logic [3:0] reqLevel;
    logic [pm_event_pkg::CtrlWidth-1:0] ctrl;
    logic [pm_event_pkg::EvWidth-1:0] status;
    logic [pm_event_pkg::EvWidth-1:0] irqEn;
    logic [2:0] rearmCnt;
    logic [31:0] resumeCount;
    logic ack;
    logic [31:0] rdata;
    logic resumeStart;
    logic stopN;
    logic extOe;
    logic smiN;
    logic activity;
    logic irqOut;
  } state_t;

  state_t s_q, s_d;
  logic [1:0] rstSync;
  logic rstnInt;
  logic extFall;
  logic [pm_event_pkg::EvWidth-1:0] events;
  logic [31:0] rdMux;

  lid_if lidBus();

  // Reset released through two flops, asserted at once
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstnInt = rstSync[1];

  lid_debounce #(.Cycles(DebounceCycles)) lidFilter (
    .clk(core_clk),
    .rstn(rstnInt),
    .lid(lidBus.filt)
  );
  assign lidBus.rawSync = s_q.lidLevel;

  function automatic logic agree(input logic [2:0] sync, input logic level);
    // A change counts once the last two stages agree
    agree = (sync[2] == sync[1]) ? sync[2] : level;
  endfunction : agree

  // Edge only when re-armed: input seen high for the re-arm span
  assign extFall = !s_q.extLevel && (s_q.rearmCnt >= 3'(pm_event_pkg::RearmPciClocks));

  always_comb begin
    events = '0;
    events[pm_event_pkg::EvExtBit] = extFall && s_q.ctrl[pm_event_pkg::CtrlExtEnBit];
    events[pm_event_pkg::EvLidBit] = lidBus.changed && s_q.ctrl[pm_event_pkg::CtrlLidSelBit]
      && s_q.ctrl[pm_event_pkg::CtrlLidEnBit];
    events[pm_event_pkg::EvResumeBlockedBit] = resume_request && s_q.ctrl[pm_event_pkg::CtrlBatSelBit]
      && s_q.ctrl[pm_event_pkg::CtrlBatBlockBit] && !s_q.batLevel;
  end

  always_comb begin
    rdMux = pm_event_pkg::UnmappedData;
    if (address == pm_event_pkg::CtrlOfs) begin
      rdMux = 32'(s_q.ctrl);
    end else if (address == pm_event_pkg::StatusOfs) begin
      rdMux = 32'(s_q.status);
    end else if (address == pm_event_pkg::IrqEnOfs) begin
      rdMux = 32'(s_q.irqEn);
    end else if (address == pm_event_pkg::PinOfs) begin
      rdMux[pm_event_pkg::PinBatBit] = s_q.batLevel;
      rdMux[pm_event_pkg::PinLidBit] = s_q.lidLevel;
      rdMux[pm_event_pkg::PinLidStableBit] = lidBus.stable;
      rdMux[pm_event_pkg::PinReqLsb +: 4] = ~s_q.reqLevel;
    end else if (address == pm_event_pkg::ResumeOfs) begin
      rdMux = s_q.resumeCount;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.batSync = {s_q.batSync[1:0], battery_low_n};
    s_d.extSync = {s_q.extSync[1:0], external_mgmt_irq_n_in};
    s_d.lidSync = {s_q.lidSync[1:0], gp_input_lid_pin};
    for (int i = 0; i < 4; i++) begin
      s_d.reqSync[i] = {s_q.reqSync[i][1:0], pci_master_request_monitor_n[i]};
      s_d.reqLevel[i] = agree(s_q.reqSync[i], s_q.reqLevel[i]);
    end
    s_d.batLevel = agree(s_q.batSync, s_q.batLevel);
    // One low PCI clock must count, so this pin skips the agreement filter
    s_d.extLevel = s_q.extSync[2];
    s_d.lidLevel = agree(s_q.lidSync, s_q.lidLevel);
    // Re-arm counter: counts high cycles, cleared while low
    if (!s_q.extLevel) begin
      s_d.rearmCnt = 3'h0;
    end else if (s_q.rearmCnt < 3'(pm_event_pkg::RearmPciClocks)) begin
      s_d.rearmCnt = s_q.rearmCnt + 3'h1;
    end
    // Bus slave: one wait cycle, then acknowledge
    s_d.ack = (read || write) && !s_q.ack;
    // Write lands at the edge where waitrequest is seen low
    if (write && s_q.ack) begin
      if (address == pm_event_pkg::CtrlOfs) begin
        s_d.ctrl = writedata[pm_event_pkg::CtrlWidth-1:0];
      end else if (address == pm_event_pkg::IrqEnOfs) begin
        s_d.irqEn = writedata[pm_event_pkg::EvWidth-1:0];
      end else if (address == pm_event_pkg::IrqClrOfs) begin
        s_d.status = s_q.status & ~writedata[pm_event_pkg::EvWidth-1:0];
      end
    end
    if (read && !s_q.ack) begin
      s_d.rdata = rdMux;
    end
    // Set wins over a clear in the same cycle
    s_d.status = s_d.status | events;
    // Resume is started only when not blocked
    s_d.resumeStart = resume_request && !events[pm_event_pkg::EvResumeBlockedBit];
    if (s_d.resumeStart) begin
      s_d.resumeCount = s_q.resumeCount + 32'h1;
    end
    // Clock stop: function bit or plain output, idle high
    s_d.stopN = s_q.ctrl[pm_event_pkg::CtrlStopSelBit] ? !s_q.ctrl[pm_event_pkg::CtrlStopBit]
      : s_q.ctrl[pm_event_pkg::CtrlGpoBit];
    // Open drain: data is always low, only the enable moves
    s_d.extOe = s_q.ctrl[pm_event_pkg::CtrlSerSmiBit];
    // Interrupt outputs follow status and enable of the same cycle
    s_d.smiN = !((s_d.status[pm_event_pkg::EvExtBit] && s_d.irqEn[pm_event_pkg::EvExtBit])
      || (s_d.status[pm_event_pkg::EvLidBit] && s_d.irqEn[pm_event_pkg::EvLidBit]));
    s_d.activity = |(~s_q.reqLevel);
    s_d.irqOut = |(s_d.status & s_d.irqEn);
  end

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      s_q <= '0;
      s_q.batSync <= 3'h7;
      s_q.extSync <= 3'h7;
      s_q.lidSync <= 3'h7;
      s_q.reqSync <= 12'hfff;
      s_q.batLevel <= 1'b1;
      s_q.extLevel <= 1'b1;
      s_q.lidLevel <= 1'b1;
      s_q.reqLevel <= 4'hf;
      s_q.ctrl <= pm_event_pkg::CtrlReset;
      s_q.stopN <= 1'b1;
      s_q.smiN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.rdata;
  assign waitrequest = !s_q.ack;
  assign resume_start = s_q.resumeStart;
  assign cpu_clock_stop_n = s_q.stopN;
  assign external_mgmt_irq_n_out = 1'b0;
  assign external_mgmt_irq_n_oe = s_q.extOe;
  assign system_mgmt_irq_n = s_q.smiN;
  assign pci_activity = s_q.activity;
  assign irq = s_q.irqOut;

  ext_edge_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    (extFall && s_q.ctrl[pm_event_pkg::CtrlExtEnBit]) |=> s_q.status[pm_event_pkg::EvExtBit])
    else $error("external edge not latched");
  rearm_gap_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    extFall |-> $past(s_q.extLevel, 1) && $past(s_q.extLevel, 4)) else $error("edge without re-arm");
  smi_drive_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    s_q.status[pm_event_pkg::EvExtBit] && s_q.irqEn[pm_event_pkg::EvExtBit] |-> !system_mgmt_irq_n)
    else $error("management interrupt missing");
  resume_block_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    (resume_request && s_q.ctrl[pm_event_pkg::CtrlBatSelBit] && s_q.ctrl[pm_event_pkg::CtrlBatBlockBit]
    && !s_q.batLevel) |=> !resume_start) else $error("resume not blocked");
  stop_low_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    s_q.ctrl[pm_event_pkg::CtrlStopSelBit] && !s_q.ctrl[pm_event_pkg::CtrlStopBit] |=> cpu_clock_stop_n)
    else $error("clock stop low while idle");
  gpo_drive_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    !s_q.ctrl[pm_event_pkg::CtrlStopSelBit] |=> cpu_clock_stop_n == $past(s_q.ctrl[pm_event_pkg::CtrlGpoBit]))
    else $error("general output mismatch");
  od_low_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    external_mgmt_irq_n_oe |-> !external_mgmt_irq_n_out) else $error("open drain driven high");
  ser_pull_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    s_q.ctrl[pm_event_pkg::CtrlSerSmiBit] |=> external_mgmt_irq_n_oe) else $error("line not pulled");
  lid_event_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    lidBus.changed && s_q.ctrl[pm_event_pkg::CtrlLidSelBit] && s_q.ctrl[pm_event_pkg::CtrlLidEnBit]
    |=> s_q.status[pm_event_pkg::EvLidBit]) else $error("lid event lost");
  req_activity_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    !(&s_q.reqLevel) |=> pci_activity) else $error("request activity missed");
  irq_level_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    irq == |(s_q.status & s_q.irqEn)) else $error("interrupt level wrong");
  smi_level_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    !system_mgmt_irq_n == ((s_q.status[pm_event_pkg::EvExtBit] && s_q.irqEn[pm_event_pkg::EvExtBit])
    || (s_q.status[pm_event_pkg::EvLidBit] && s_q.irqEn[pm_event_pkg::EvLidBit])))
    else $error("management interrupt level wrong");
  resume_pass_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    (resume_request && !(s_q.ctrl[pm_event_pkg::CtrlBatSelBit] && s_q.ctrl[pm_event_pkg::CtrlBatBlockBit]
    && !s_q.batLevel)) |=> resume_start) else $error("resume not started");
  ext_once_a: assert property (@(posedge core_clk) disable iff (!rstnInt)
    extFall |=> !extFall) else $error("edge counted twice");
  resume_cov: cover property (@(posedge core_clk) disable iff (!rstnInt) resume_start);
  serial_cov: cover property (@(posedge core_clk) disable iff (!rstnInt) external_mgmt_irq_n_oe);
  ext_cov: cover property (@(posedge core_clk) disable iff (!rstnInt) events[pm_event_pkg::EvExtBit]);
  lid_cov: cover property (@(posedge core_clk) disable iff (!rstnInt) events[pm_event_pkg::EvLidBit]);
  block_cov: cover property (@(posedge core_clk) disable iff (!rstnInt)
    events[pm_event_pkg::EvResumeBlockedBit]);
endmodule : power_event_inputs

/* File: shared/pm_event_pkg.sv */
// Package of constants for the power-management event inputs.
// Assumes a 250 MHz core clock and a 32-bit Avalon-MM register slave.
package pm_event_pkg;
  // Register word addresses, one 32-bit register each
  localparam logic [3:0] CtrlOfs = 4'h0;
  localparam logic [3:0] StatusOfs = 4'h1;
  localparam logic [3:0] IrqEnOfs = 4'h2;
  localparam logic [3:0] IrqClrOfs = 4'h3;
  localparam logic [3:0] PinOfs = 4'h4;
  localparam logic [3:0] ResumeOfs = 4'h5;
  // Control fields
  localparam int CtrlBatSelBit = 0;
  localparam int CtrlBatBlockBit = 1;
  localparam int CtrlStopSelBit = 2;
  localparam int CtrlStopBit = 3;
  localparam int CtrlGpoBit = 4;
  localparam int CtrlExtEnBit = 5;
  localparam int CtrlLidSelBit = 6;
  localparam int CtrlLidEnBit = 7;
  localparam int CtrlSerSmiBit = 8;
  localparam int CtrlWidth = 9;
  localparam logic [8:0] CtrlReset = 9'h045;
  // Event fields
  localparam int EvExtBit = 0;
  localparam int EvLidBit = 1;
  localparam int EvResumeBlockedBit = 2;
  localparam int EvWidth = 3;
  // Pin readback fields
  localparam int PinBatBit = 0;
  localparam int PinLidBit = 1;
  localparam int PinLidStableBit = 2;
  localparam int PinReqLsb = 4;
  // Timing
  localparam int ClkMhz = 250;
  localparam int DebounceMs = 16;
  localparam int DebounceCycles = DebounceMs * 1000 * ClkMhz;
  localparam int RearmPciClocks = 4;
  localparam logic [31:0] UnmappedData = 32'h0000_0000;
endpackage : pm_event_pkg

/* File: shared/lid_if.sv */
// Interface between the top module and the lid debouncer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface lid_if;
  logic rawSync;
  logic stable;
  logic changed;
  modport core (output rawSync, input stable, input changed);
  modport filt (input rawSync, output stable, output changed);
endinterface : lid_if

/* File: verilog/lid_debounce.sv */
// Debouncer for the lid input.
// Assumes an already synchronised input; interval given as a parameter.
`timescale 1ns/100ps
module lid_debounce #(
  parameter int Cycles = pm_event_pkg::DebounceCycles
) (
  input wire logic clk,
  input wire logic rstn,
  lid_if.filt lid
);
  typedef struct packed {
    logic [31:0] count;
    logic stable;
    logic changed;
  } state_t;
  state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.changed = 1'b0;
    if (lid.rawSync == s_q.stable) begin
      s_d.count = 32'h0;
    end else if (s_q.count >= 32'(Cycles - 1)) begin
      s_d.stable = lid.rawSync;
      s_d.changed = 1'b1;
      s_d.count = 32'h0;
    end else begin
      s_d.count = s_q.count + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.stable <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign lid.stable = s_q.stable;
  assign lid.changed = s_q.changed;
  stable_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (lid.rawSync == s_q.stable) |=> !s_q.changed) else $error("lid change without held difference");
endmodule : lid_debounce

/* File: tb/pm_event_partner.sv */
// Far-side model: external requester on the open-drain management interrupt line.
// Assumes a pull-up on the line; the device output enable pulls it low.
`timescale 1ns/100ps
module pm_event_partner (
  input wire logic core_clk,
  input wire logic devOe,
  output logic extLine
);
  logic reqLow = 1'b0;
  // Pull-up wins only when nobody pulls low
  assign extLine = (devOe || reqLow) ? 1'b0 : 1'b1;
  task automatic pulseExt(input int lowCycles);
    @(posedge core_clk);
    reqLow <= 1'b1;
    repeat (lowCycles) @(posedge core_clk);
    reqLow <= 1'b0;
    // Held high past the re-arm span so back-to-back pulses stay legal
    repeat (2 * pm_event_pkg::RearmPciClocks) @(posedge core_clk);
  endtask : pulseExt
endmodule : pm_event_partner

/* File: tb/test_power_event_inputs.sv */
// Self-checking bench for the power-management event inputs.
// Assumes a debounce span shortened to 16 cycles and a one-cycle bus answer.
`timescale 1ns/100ps
`define CK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module test_power_event_inputs;
  localparam logic [31:0] Ctl0 = {23'h0, pm_event_pkg::CtrlReset};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic battery_low_n = 1'b1;
  logic resume_request = 1'b0;
  logic gp_input_lid_pin = 1'b1;
  logic [3:0] reqN = 4'hf;
  logic [31:0] readdata, rd;
  logic waitrequest, resume_start, cpu_clock_stop_n, extIn, extOut, extOe, system_mgmt_irq_n;
  logic pci_activity, irq;
  int miscompares = 0;
  int comparisons = 0;
  always #2 core_clk = ~core_clk;
  power_event_inputs #(.DebounceCycles(16)) power_event_inputs_inst (.core_clk(core_clk), .rstn(rstn),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .battery_low_n(battery_low_n), .resume_request(resume_request),
    .resume_start(resume_start), .cpu_clock_stop_n(cpu_clock_stop_n), .external_mgmt_irq_n_in(extIn),
    .external_mgmt_irq_n_out(extOut), .external_mgmt_irq_n_oe(extOe), .system_mgmt_irq_n(system_mgmt_irq_n),
    .gp_input_lid_pin(gp_input_lid_pin), .pci_master_request_monitor_n(reqN), .pci_activity(pci_activity),
    .irq(irq));
  pm_event_partner pm_event_partner_inst (.core_clk(core_clk), .devOe(extOe), .extLine(extIn));
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= wd;
    // Only the watchdog ends a wait that never sees an answer
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic pulseResume();
    @(posedge core_clk);
    resume_request <= 1'b1;
    @(posedge core_clk);
    resume_request <= 1'b0;
    @(posedge core_clk);
  endtask : pulseResume
  task automatic checkReset();
    bus(0, pm_event_pkg::CtrlOfs, 0);
    `CK("ctrl", Ctl0, rd)
    `CK("stop", 1'b1, cpu_clock_stop_n)
    bus(0, 4'hf, 0);
    `CK("unmapped", pm_event_pkg::UnmappedData, rd)
    bus(1, pm_event_pkg::IrqClrOfs, 32'h7);
  endtask : checkReset
  task automatic checkExt();
    bus(1, pm_event_pkg::IrqEnOfs, 32'h3);
    bus(0, pm_event_pkg::IrqEnOfs, 0);
    `CK("irqEn", 32'h3, rd)
    bus(1, pm_event_pkg::CtrlOfs, Ctl0 | 32'h0a0);
    pm_event_partner_inst.pulseExt(1);
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("extSt", 1'b1, rd[pm_event_pkg::EvExtBit])
    `CK("smi", 1'b0, system_mgmt_irq_n)
    `CK("irq", 1'b1, irq)
    bus(1, pm_event_pkg::IrqEnOfs, 32'h0);
    tick(3);
    `CK("irqMask", 1'b0, irq)
    bus(1, pm_event_pkg::IrqEnOfs, 32'h3);
    bus(1, pm_event_pkg::IrqClrOfs, 32'h1);
    tick(3);
    `CK("smiClr", 1'b1, system_mgmt_irq_n)
    pm_event_partner_inst.pulseExt(1);
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("rearm", 1'b1, rd[pm_event_pkg::EvExtBit])
    bus(1, pm_event_pkg::IrqClrOfs, 32'h1);
    bus(1, pm_event_pkg::CtrlOfs, Ctl0 | 32'h080);
    pm_event_partner_inst.pulseExt(1);
    `CK("smiOff", 1'b1, system_mgmt_irq_n)
  endtask : checkExt
  task automatic checkLid();
    bus(1, pm_event_pkg::IrqClrOfs, 32'h7);
    gp_input_lid_pin <= 1'b0;
    tick(6);
    gp_input_lid_pin <= 1'b1;
    tick(30);
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("glitch", 1'b0, rd[pm_event_pkg::EvLidBit])
    gp_input_lid_pin <= 1'b0;
    tick(12);
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("early", 1'b0, rd[pm_event_pkg::EvLidBit])
    tick(20);
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("lidFall", 1'b1, rd[pm_event_pkg::EvLidBit])
    `CK("lidSmi", 1'b0, system_mgmt_irq_n)
    bus(1, pm_event_pkg::IrqClrOfs, 32'h2);
    gp_input_lid_pin <= 1'b1;
    tick(40);
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("lidRise", 1'b1, rd[pm_event_pkg::EvLidBit])
    bus(1, pm_event_pkg::IrqClrOfs, 32'h2);
    bus(1, pm_event_pkg::CtrlOfs, (Ctl0 & ~32'h040) | 32'h080);
    gp_input_lid_pin <= 1'b0;
    tick(40);
    bus(0, pm_event_pkg::PinOfs, 0);
    `CK("lidGpi", 1'b0, rd[pm_event_pkg::PinLidBit])
    `CK("lidStable", 1'b0, rd[pm_event_pkg::PinLidStableBit])
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("lidOff", 1'b0, rd[pm_event_pkg::EvLidBit])
    gp_input_lid_pin <= 1'b1;
    tick(40);
  endtask : checkLid
  task automatic checkResume();
    bus(1, pm_event_pkg::CtrlOfs, Ctl0 | 32'h002);
    battery_low_n <= 1'b0;
    tick(6);
    pulseResume();
    `CK("blocked", 1'b0, resume_start)
    bus(0, pm_event_pkg::StatusOfs, 0);
    `CK("blkSt", 1'b1, rd[pm_event_pkg::EvResumeBlockedBit])
    battery_low_n <= 1'b1;
    tick(6);
    pulseResume();
    `CK("resume", 1'b1, resume_start)
    bus(1, pm_event_pkg::CtrlOfs, (Ctl0 & ~32'h001) | 32'h002);
    battery_low_n <= 1'b0;
    tick(6);
    pulseResume();
    `CK("unsel", 1'b1, resume_start)
    bus(0, pm_event_pkg::PinOfs, 0);
    `CK("batGpi", 1'b0, rd[pm_event_pkg::PinBatBit])
    bus(0, pm_event_pkg::ResumeOfs, 0);
    `CK("resCnt", 32'h2, rd)
    battery_low_n <= 1'b1;
    bus(1, pm_event_pkg::IrqClrOfs, 32'h7);
  endtask : checkResume
  task automatic checkStop();
    logic [31:0] v [4] = '{Ctl0 | 32'h008, Ctl0, 32'h051, 32'h041};
    logic e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      bus(1, pm_event_pkg::CtrlOfs, v[i]);
      tick(3);
      `CK("clkStop", e[i], cpu_clock_stop_n)
    end
  endtask : checkStop
  task automatic checkSerial();
    bus(1, pm_event_pkg::CtrlOfs, Ctl0 | 32'h100);
    tick(3);
    `CK("oe", 1'b1, extOe)
    `CK("out", 1'b0, extOut)
    bus(1, pm_event_pkg::CtrlOfs, Ctl0);
    tick(3);
    `CK("oeOff", 1'b0, extOe)
  endtask : checkSerial
  task automatic checkReq();
    reqN <= 4'b1011;
    tick(6);
    `CK("act", 1'b1, pci_activity)
    bus(0, pm_event_pkg::PinOfs, 0);
    `CK("reqPins", 4'b0100, rd[7:4])
    reqN <= 4'hf;
    tick(6);
    `CK("idle", 1'b0, pci_activity)
  endtask : checkReq
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    tick(40);
    checkReset();
    checkExt();
    checkLid();
    checkResume();
    checkStop();
    checkSerial();
    checkReq();
    test_done();
  end
endmodule : test_power_event_inputs
